/* File: bench/ods_dc_model.sv */
// partner model: distributed time base and process image collector
module ods_dc_model (
    input  wire logic        clk_in,           // clock
    input  wire logic        nrst_in,          // reset, active low
    input  wire logic        image_update_in,  // image released by the sampler
    output logic      [31:0] dc_time_out,      // local time, ns
    output logic      [15:0] image_cnt_out     // images collected
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) dc_time_out <= 32'h0000_1000;
        else dc_time_out <= dc_time_out + 32'(ods_pkg::CLK_PERIOD_NS);
    end
    // a count of collected images shows lost or doubled frames
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) image_cnt_out <= 16'h0;
        else if (image_update_in) image_cnt_out <= image_cnt_out + 16'h1;
    end
endmodule // ods_dc_model

/* File: bench/ods_sampler_asserts.sv */
// checker: port-level assertions of the oversampled input sampler
module ods_sampler_asserts #(
    parameter int STARTUP = ods_pkg::STARTUP_CYCLES
) (
    input logic        clk_in,           // clock
    input logic        nrst_in,          // reset, active low
    input logic        hsel_in,          // select
    input logic [31:0] haddr_in,         // address
    input logic [1:0]  htrans_in,        // transfer type
    input logic        hwrite_in,        // write
    input logic [2:0]  hsize_in,         // size
    input logic [31:0] hwdata_in,        // write data
    input logic        hready_in,        // bus ready
    input logic [31:0] hrdata_out,       // read data
    input logic        hreadyout_out,    // slave ready
    input logic        hresp_out,        // response
    input logic [1:0]  raw_in,           // raw levels
    input logic [31:0] dc_time_in,       // local time
    input logic        sample_tick_out,  // sample pulse
    input logic        cycle_tick_out,   // cycle pulse
    input logic        image_update_out, // image pulse
    input logic        operational_out   // operational level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] tcnt;
    logic [15:0] scnt;
    logic [15:0] slast;
    logic [15:0] gap;
    logic [15:0] glast;
    logic [1:0]  gseen;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // cycle ticks counted while start-up runs
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) tcnt <= 16'h0;
        else if (operational_out) tcnt <= 16'h0;
        else if (cycle_tick_out) tcnt <= tcnt + 16'h1;
    end
    // samples per cycle; the tick's own sample opens the count
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scnt  <= 16'h0;
            slast <= 16'h0;
        end else if (cycle_tick_out) begin
            scnt  <= 16'h1;
            slast <= scnt;
        end else if (sample_tick_out) scnt <= scnt + 16'h1;
    end
    // spacing is trusted only after two gaps seen in operation
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap   <= 16'h0;
            glast <= 16'h0;
        end else if (sample_tick_out) begin
            gap   <= 16'h1;
            glast <= gap;
        end else gap <= gap + 16'h1;
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) gseen <= 2'h0;
        else if (!operational_out) gseen <= 2'h0;
        else if (sample_tick_out && gseen != 2'h2) gseen <= gseen + 2'h1;
    end
    property p_bus_okay;
        hreadyout_out && !hresp_out;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("slave not ready or not okay");
    property p_tick_sample;
        cycle_tick_out |-> sample_tick_out;
    endproperty
    a_tick_sample: assert property (p_tick_sample) else $error("cycle tick without sample");
    property p_tick_pulse;
        cycle_tick_out |=> !cycle_tick_out;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("cycle tick too long");
    property p_img_tick;
        image_update_out |-> cycle_tick_out;
    endproperty
    a_img_tick: assert property (p_img_tick) else $error("image released off the tick");
    property p_img_oper;
        image_update_out |-> ##[0:1] operational_out;
    endproperty
    a_img_oper: assert property (p_img_oper) else $error("image before operational");
    property p_oper_img;
        operational_out && cycle_tick_out |-> image_update_out;
    endproperty
    a_oper_img: assert property (p_oper_img) else $error("operational tick without image");
    property p_startup;
        $rose(operational_out) |-> (tcnt == STARTUP - 1 && cycle_tick_out) || tcnt == STARTUP;
    endproperty
    a_startup: assert property (p_startup) else $error("start-up tick count wrong");
    property p_count;
        operational_out && cycle_tick_out |-> scnt == slast;
    endproperty
    a_count: assert property (p_count) else $error("samples per cycle changed");
    property p_gap;
        sample_tick_out && gseen == 2'h2 |-> gap == glast;
    endproperty
    a_gap: assert property (p_gap) else $error("sample spacing uneven");
endmodule // ods_sampler_asserts

bind ods_sampler ods_sampler_asserts #(.STARTUP(STARTUP)) chk_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .raw_in(raw_in), .dc_time_in(dc_time_in), .sample_tick_out(sample_tick_out),
    .cycle_tick_out(cycle_tick_out), .image_update_out(image_update_out), .operational_out(operational_out)
);

/* File: bench/testbench.sv */
// testbench: register-level tests of the oversampled input sampler
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
    localparam int STU = 3;
    localparam int CYC = 4000;
    logic        clk_in, nrst_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
    logic        sample_tick_out, cycle_tick_out, image_update_out, operational_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, dc_time;
    logic [1:0]  htrans_in, raw_in = 2'h0;
    logic [2:0]  hsize_in;
    logic [15:0] icnt;
    int          num_errors = 0;
    int          comparisons = 0;
    int          idx = 0;
    int          nfac = 1;
    ods_sampler #(.STARTUP(STU)) dut_u (
        .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .raw_in(raw_in),
        .dc_time_in(dc_time), .sample_tick_out(sample_tick_out), .cycle_tick_out(cycle_tick_out),
        .image_update_out(image_update_out), .operational_out(operational_out)
    );
    ods_dc_model pm_u (.clk_in(clk_in), .nrst_in(nrst_in), .image_update_in(image_update_out),
        .dc_time_out(dc_time), .image_cnt_out(icnt));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    function automatic logic pat(input int ch, input int k);
        return ch == 0 ? (k % 3 == 0) : (k % 4 < 2);
    endfunction
    function automatic logic [31:0] expw(input int ch, input int w);
        logic [31:0] v;
        v = 32'h0;
        for (int b = 0; b < 32; b++) v[b] = (32 * w + b < nfac) && pat(ch, 32 * w + b);
        return v;
    endfunction
    // next level is set right after each sample, well before the next one
    always @(posedge clk_in) begin
        if (sample_tick_out === 1'b1) begin
            idx = (cycle_tick_out === 1'b1) ? 0 : idx + 1;
            raw_in <= {pat(1, (idx + 1) % nfac), pat(0, (idx + 1) % nfac)};
        end
    end
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel_in   <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in  <= {20'h0, a};
        hwrite_in <= w;
        hsize_in  <= 3'h2;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    task automatic wait_for(input int s);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while ((s == 0 ? cycle_tick_out : image_update_out) !== 1'b1 && n < 5000);
        if (n >= 5000) `CHK(1'b0, 1'b1)
    endtask
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #600000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        int          f, neff, n, t, np;
        int          fl[5] = '{1, 2, 5, 100, 3};
        logic [31:0] c0, n0;
        logic [15:0] i0;
        nrst_in = 1'b0;
        hsel_in = 1'b0;
        haddr_in = 32'h0;
        htrans_in = 2'h0;
        hwrite_in = 1'b0;
        hsize_in = 3'h2;
        hwdata_in = 32'h0;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        chk_rd(ods_pkg::OFS_CTRL, {29'h0, ods_pkg::CTRL_RESET});
        chk_rd(ods_pkg::OFS_CYCLE_PERIOD, ods_pkg::CYCLE_PER_RESET);
        chk_rd(ods_pkg::OFS_FACTOR, {22'h0, ods_pkg::FACTOR_RESET});
        wr(12'h030, 32'hFFFF_FFFF);
        chk_rd(12'h030, 32'h0);
        chk_rd(12'h100, 32'h0);
        for (int i = 0; i < 5; i++) begin
            f = fl[i];
            neff = (CYC % f == 0) ? f : 1;
            wr(ods_pkg::OFS_CTRL, 32'h0);
            wr(ods_pkg::OFS_FACTOR, f);
            wr(ods_pkg::OFS_CYCLE_PERIOD, CYC);
            nfac = neff;
            wr(ods_pkg::OFS_CTRL, i == 4 ? 32'h1 : i == 3 ? 32'h7 : 32'h3);
            n = 0;
            t = 0;
            while (operational_out !== 1'b1 && n < 20000) begin
                @(posedge clk_in);
                n++;
                if (cycle_tick_out === 1'b1) t++;
            end
            `CHK(t, STU)
            // same period each run, so only the input-reference shift moves the start
            if (i == 3) `CHK(np - n, int'(ods_pkg::IREF_SHIFT_NS) / ods_pkg::CLK_PERIOD_NS)
            np = n;
            wait_for(1);
            wait_for(1);
            ahb(1'b0, ods_pkg::OFS_CYCLE_COUNT, 32'h0, c0);
            ahb(1'b0, ods_pkg::OFS_NEXT_TIME, 32'h0, n0);
            i0 = icnt;
            chk_rd(ods_pkg::OFS_STATUS, {6'h0, 10'(neff), 14'h0, 1'(neff == f), 1'b1});
            chk_rd(ods_pkg::OFS_SAMPLE_PER, CYC / neff);
            for (int ch = 0; ch < 2; ch++)
                for (int w = 0; w < 4; w++)
                    chk_rd(12'(ch * 256 + 256 + w * 4), expw(ch, w));
            wait_for(0);
            chk_rd(ods_pkg::OFS_CYCLE_COUNT, {16'h0, c0[15:0] + 16'h1});
            chk_rd(ods_pkg::OFS_NEXT_TIME, i == 4 ? 32'h0 : n0 + CYC);
            `CHK(16'(icnt - i0), 16'h1)
        end
        report_and_stop();
    end
endmodule // testbench

/* File: hdl/ods_pkg.sv */
// package: constants, register map and carrier types of the oversampled input sampler
// Contract
// [R1] capture each input bit per sample tick
// [R2] controller picks factor from predefined set
// [R3] sample period is cycle period over factor
// [R4] controller requests only offered factors
// [R5] bad factor runs as factor one
// [R6] 1 ms: 1,2,5,100 valid, 3 not
// [R7] about sixty cycles before first data
// [R8] 16-bit cycle count shared by channels
// [R9] controller checks counter for lost frames
// [R10] sample field scales from 1 bit
// [R11] padding carries nothing, controller ignores it
// [R12] cycle tick equals first sample tick
// [R13] report next cycle tick time, 32 bit
// [R14] next cycle time field is optional
// [R15] controller derives sample times from it
// [R16] receiver uses bits or bytes by factor
// [R17] input reference moves cycle tick earlier
// [R18] raw sampling, no filter
// [R19] earliest sample in lowest bit
// [R20] cycle tick clears sample write pointer
package ods_pkg;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          CHANNELS         = 2;
    localparam int          MAX_FACTOR       = 1000;
    localparam int          SAMPLE_WORDS     = 32;
    localparam int          STARTUP_CYCLES   = 60;
    localparam logic [31:0] IREF_SHIFT_NS    = 32'h0000_07D0;
    localparam logic [11:0] OFS_CTRL         = 12'h000;
    localparam logic [11:0] OFS_CYCLE_PERIOD = 12'h004;
    localparam logic [11:0] OFS_FACTOR       = 12'h008;
    localparam logic [11:0] OFS_STATUS       = 12'h00C;
    localparam logic [11:0] OFS_CYCLE_COUNT  = 12'h010;
    localparam logic [11:0] OFS_NEXT_TIME    = 12'h014;
    localparam logic [11:0] OFS_SAMPLE_PER   = 12'h018;
    localparam logic [3:0]  PAGE_CH0         = 4'h1;
    localparam logic [3:0]  PAGE_CH1         = 4'h2;
    localparam int          CTRL_ENABLE_BIT  = 0;
    localparam int          CTRL_NEXT_EN_BIT = 1;
    localparam int          CTRL_IREF_BIT    = 2;
    localparam int          STAT_OPER_BIT    = 0;
    localparam int          STAT_VALID_BIT   = 1;
    localparam int          STAT_FACTOR_LSB  = 16;
    localparam logic [2:0]  CTRL_RESET       = 3'h2;
    localparam logic [31:0] CYCLE_PER_RESET  = 32'h000F_4240;
    localparam logic [9:0]  FACTOR_RESET     = 10'h001;

    typedef struct packed {
        logic        enable;
        logic        next_time_en;
        logic        iref_en;
        logic [31:0] cycle_period;
        logic [9:0]  factor;
    } ods_cfg_t;

    typedef struct packed {
        logic        operational;
        logic        factor_valid;
        logic [9:0]  eff_factor;
        logic [15:0] cycle_count;
        logic [31:0] next_time;
        logic [31:0] sample_period;
    } ods_stat_t;
endpackage

/* File: hdl/ods_sampler.sv */
// module: two-channel oversampled digital input sampler with AHB-Lite process image
module ods_sampler #(
    parameter int STARTUP = ods_pkg::STARTUP_CYCLES
) (
    input  wire logic        clk_in,            // 100 MHz clock
    input  wire logic        nrst_in,           // async reset, active low
    input  wire logic        hsel_in,           // ahb slave select
    input  wire logic [31:0] haddr_in,          // ahb address
    input  wire logic [1:0]  htrans_in,         // ahb transfer type
    input  wire logic        hwrite_in,         // ahb write
    input  wire logic [2:0]  hsize_in,          // ahb size, word only
    input  wire logic [31:0] hwdata_in,         // ahb write data
    input  wire logic        hready_in,         // ahb bus ready
    output logic      [31:0] hrdata_out,        // ahb read data
    output logic             hreadyout_out,     // ahb slave ready
    output logic             hresp_out,         // ahb response, always okay
    input  wire logic [1:0]  raw_in,            // raw input levels
    input  wire logic [31:0] dc_time_in,        // synchronised local time, ns
    output logic             sample_tick_out,   // pulse per sample taken
    output logic             cycle_tick_out,    // pulse per cycle tick
    output logic             image_update_out,  // pulse when process image released
    output logic             operational_out    // process data delivered
);
    typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_RUN} ods_state_t;

    ods_state_t             state_reg;
    ods_pkg::ods_cfg_t      cfg_reg;
    ods_pkg::ods_cfg_t      act_reg;
    ods_pkg::ods_stat_t     stat;
    logic [31:0]            div_dvd_reg;
    logic [31:0]            div_quot_reg;
    logic [10:0]            div_rem_reg;
    logic [5:0]             div_cnt_reg;
    logic [10:0]            rem_shift;
    logic [9:0]             eff_factor_reg;
    logic                   factor_valid_reg;
    logic [31:0]            sample_period_reg;
    logic [31:0]            next_cyc_reg;
    logic [31:0]            next_smp_reg;
    logic [9:0]             smp_cnt_reg;
    logic [15:0]            cycle_count_reg;
    logic [6:0]             startup_reg;
    logic                   oper_reg;
    logic                   cyc_hit;
    logic                   smp_hit;
    logic [31:0]            cap_reg  [ods_pkg::CHANNELS][ods_pkg::SAMPLE_WORDS];
    logic [31:0]            snap_reg [ods_pkg::CHANNELS][ods_pkg::SAMPLE_WORDS];
    logic                   wr_pend_reg;
    logic [11:0]            wr_addr_reg;
    logic                   addr_phase;
    logic [11:0]            a_ofs;
    logic [31:0]            rd_next;

    // wrap-safe "time has reached target" on the 32-bit clock
    function automatic logic reached(input logic [31:0] now, input logic [31:0] tgt);
        logic [31:0] diff;
        diff = now - tgt;
        return ~diff[31];
    endfunction

    // only the offered oversampling settings count as plausible
    function automatic logic offered(input logic [9:0] f);
        logic ok;
        ok = 1'b0;
        unique case (f)
            10'd1, 10'd2, 10'd3, 10'd4, 10'd5, 10'd8, 10'd10, 10'd16, 10'd20, 10'd40,
            10'd50, 10'd100, 10'd200, 10'd400, 10'd500, 10'd1000: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    assign stat.operational   = oper_reg;
    assign stat.factor_valid  = factor_valid_reg;
    assign stat.eff_factor    = eff_factor_reg;
    assign stat.cycle_count   = cycle_count_reg;
    assign stat.next_time     = act_reg.next_time_en ? next_cyc_reg : 32'h0000_0000; // [R14]
    assign stat.sample_period = sample_period_reg;

    // ---------------- ahb-lite slave ----------------
    assign addr_phase = hsel_in & htrans_in[1] & hready_in;
    assign a_ofs      = haddr_in[11:0];

    always_comb begin
        rd_next = 32'h0000_0000;
        if (a_ofs[11:8] == ods_pkg::PAGE_CH0) begin
            rd_next = oper_reg ? snap_reg[0][a_ofs[6:2]] : 32'h0000_0000;
        end else if (a_ofs[11:8] == ods_pkg::PAGE_CH1) begin
            rd_next = oper_reg ? snap_reg[1][a_ofs[6:2]] : 32'h0000_0000;
        end else begin
            unique case ({a_ofs[11:2], 2'b00})
                ods_pkg::OFS_CTRL:         rd_next = {29'h0, cfg_reg.iref_en, cfg_reg.next_time_en, cfg_reg.enable};
                ods_pkg::OFS_CYCLE_PERIOD: rd_next = cfg_reg.cycle_period;
                ods_pkg::OFS_FACTOR:       rd_next = {22'h0, cfg_reg.factor};
                ods_pkg::OFS_STATUS: begin
                    rd_next[ods_pkg::STAT_OPER_BIT]  = stat.operational;
                    rd_next[ods_pkg::STAT_VALID_BIT] = stat.factor_valid;
                    rd_next[ods_pkg::STAT_FACTOR_LSB +: 10] = stat.eff_factor;
                end
                ods_pkg::OFS_CYCLE_COUNT:  rd_next = {16'h0, stat.cycle_count};       // [R8]
                ods_pkg::OFS_NEXT_TIME:    rd_next = stat.next_time;                  // [R13]
                ods_pkg::OFS_SAMPLE_PER:   rd_next = stat.sample_period;
                default:                   rd_next = 32'h0000_0000;                   // [R11]
            endcase
        end
    end

    // zero wait states: read data is prepared during the address phase
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            if (addr_phase && !hwrite_in) begin
                hrdata_out <= rd_next;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_phase & hwrite_in;
            if (addr_phase) begin
                wr_addr_reg <= {a_ofs[11:2], 2'b00};
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_reg.enable       <= ods_pkg::CTRL_RESET[ods_pkg::CTRL_ENABLE_BIT];
            cfg_reg.next_time_en <= ods_pkg::CTRL_RESET[ods_pkg::CTRL_NEXT_EN_BIT];
            cfg_reg.iref_en      <= ods_pkg::CTRL_RESET[ods_pkg::CTRL_IREF_BIT];
            cfg_reg.cycle_period <= ods_pkg::CYCLE_PER_RESET;
            cfg_reg.factor       <= ods_pkg::FACTOR_RESET;
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                ods_pkg::OFS_CTRL: begin
                    cfg_reg.enable       <= hwdata_in[ods_pkg::CTRL_ENABLE_BIT];
                    cfg_reg.next_time_en <= hwdata_in[ods_pkg::CTRL_NEXT_EN_BIT];
                    cfg_reg.iref_en      <= hwdata_in[ods_pkg::CTRL_IREF_BIT];
                end
                ods_pkg::OFS_CYCLE_PERIOD: cfg_reg.cycle_period <= hwdata_in;
                ods_pkg::OFS_FACTOR:       cfg_reg.factor       <= hwdata_in[9:0];
                default: ;
            endcase
        end
    end

    // ---------------- sequencing ----------------
    // settings are latched at start; changing them needs a disable/enable round
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= ST_IDLE;
            act_reg   <= '0;
        end else if (!cfg_reg.enable) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    act_reg   <= cfg_reg;
                    state_reg <= ST_DIVIDE;
                end
                ST_DIVIDE: if (div_cnt_reg == 6'd32) state_reg <= ST_RUN;
                ST_RUN:    state_reg <= ST_RUN;
                default:   state_reg <= ST_IDLE;
            endcase
        end
    end

    // serial restoring divide: one quotient bit per clock, 32 clocks
    assign rem_shift = {div_rem_reg[9:0], div_dvd_reg[31]};

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_dvd_reg  <= 32'h0000_0000;
            div_quot_reg <= 32'h0000_0000;
            div_rem_reg  <= 11'h000;
            div_cnt_reg  <= 6'h00;
        end else if (state_reg == ST_IDLE) begin
            div_dvd_reg  <= cfg_reg.cycle_period;
            div_quot_reg <= 32'h0000_0000;
            div_rem_reg  <= 11'h000;
            div_cnt_reg  <= 6'h00;
        end else if (state_reg == ST_DIVIDE && div_cnt_reg != 6'd32) begin
            div_dvd_reg <= {div_dvd_reg[30:0], 1'b0};
            div_cnt_reg <= div_cnt_reg + 6'd1;
            if (rem_shift >= {1'b0, act_reg.factor}) begin                      // [R3]
                div_rem_reg  <= rem_shift - {1'b0, act_reg.factor};
                div_quot_reg <= {div_quot_reg[30:0], 1'b1};
            end else begin
                div_rem_reg  <= rem_shift;
                div_quot_reg <= {div_quot_reg[30:0], 1'b0};
            end
        end
    end

    // a non-whole ns period or a factor off the list falls back to one sample
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            factor_valid_reg  <= 1'b0;
            eff_factor_reg    <= ods_pkg::FACTOR_RESET;
            sample_period_reg <= ods_pkg::CYCLE_PER_RESET;
        end else if (state_reg == ST_DIVIDE && div_cnt_reg == 6'd32) begin
            if (offered(act_reg.factor) && div_rem_reg == 11'h000 && div_quot_reg != 32'h0) begin // [R3] [R6]
                factor_valid_reg  <= 1'b1;
                eff_factor_reg    <= act_reg.factor;
                sample_period_reg <= div_quot_reg;
            end else begin
                factor_valid_reg  <= 1'b0;                                       // [R5]
                eff_factor_reg    <= ods_pkg::FACTOR_RESET;
                sample_period_reg <= act_reg.cycle_period;
            end
        end
    end

    // ---------------- tick generation ----------------
    assign cyc_hit = (state_reg == ST_RUN) && reached(dc_time_in, next_cyc_reg);
    assign smp_hit = (state_reg == ST_RUN) && !cyc_hit && (smp_cnt_reg < eff_factor_reg) &&
                     reached(dc_time_in, next_smp_reg);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            next_cyc_reg <= 32'h0000_0000;
            next_smp_reg <= 32'h0000_0000;
            smp_cnt_reg  <= 10'h000;
        end else if (state_reg == ST_DIVIDE) begin
            // first tick one period out, pulled forward when referenced to the input
            next_cyc_reg <= dc_time_in + act_reg.cycle_period - (act_reg.iref_en ? ods_pkg::IREF_SHIFT_NS
                                                                                 : 32'h0000_0000); // [R17]
            // parked past any factor: the stale sample time of a former run fires no sample
            smp_cnt_reg  <= 10'h3FF;                                             // [R20]
        end else if (cyc_hit) begin
            next_cyc_reg <= next_cyc_reg + act_reg.cycle_period;                 // [R13]
            next_smp_reg <= next_cyc_reg + sample_period_reg;                    // [R12]
            smp_cnt_reg  <= 10'h001;                                             // [R20]
        end else if (smp_hit) begin
            next_smp_reg <= next_smp_reg + sample_period_reg;
            smp_cnt_reg  <= smp_cnt_reg + 10'h001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sample_tick_out <= 1'b0;
            cycle_tick_out  <= 1'b0;
        end else begin
            sample_tick_out <= cyc_hit | smp_hit;                                // [R12]
            cycle_tick_out  <= cyc_hit;
        end
    end

    // ---------------- sample capture ----------------
    // raw level straight in, no debounce, so microsecond pulses survive
    for (genvar ch = 0; ch < ods_pkg::CHANNELS; ch++) begin : g_chan
        for (genvar w = 0; w < ods_pkg::SAMPLE_WORDS; w++) begin : g_word
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    cap_reg[ch][w]  <= 32'h0000_0000;
                    snap_reg[ch][w] <= 32'h0000_0000;
                end else if (cyc_hit) begin
                    // unused bits stay zero, so the field scales with the factor
                    cap_reg[ch][w] <= (w == 0) ? {31'h0, raw_in[ch]} : 32'h0000_0000; // [R1] [R19] [R10]
                    if (oper_reg || startup_reg == 7'(STARTUP - 1)) begin
                        snap_reg[ch][w] <= cap_reg[ch][w];
                    end
                end else if (smp_hit && smp_cnt_reg[9:5] == 5'(w)) begin
                    cap_reg[ch][w][smp_cnt_reg[4:0]] <= raw_in[ch];              // [R1] [R18] [R19]
                end
            end
        end
    end

    // ---------------- cycle counter and start-up ----------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cycle_count_reg <= 16'h0000;
        end else if (cyc_hit) begin
            cycle_count_reg <= cycle_count_reg + 16'h0001;                       // [R8]
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            startup_reg <= 7'h00;
            oper_reg    <= 1'b0;
        end else if (state_reg != ST_RUN) begin
            startup_reg <= 7'h00;
            oper_reg    <= 1'b0;
        end else if (cyc_hit && !oper_reg) begin
            startup_reg <= startup_reg + 7'h01;
            if (startup_reg == 7'(STARTUP - 1)) begin
                oper_reg <= 1'b1;                                                // [R7]
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            image_update_out <= 1'b0;
            operational_out  <= 1'b0;
        end else begin
            image_update_out <= cyc_hit && (oper_reg || startup_reg == 7'(STARTUP - 1)); // [R7]
            operational_out  <= oper_reg;
        end
    end
endmodule // ods_sampler
